//--- fswc_pkg.sv
// shared constants, register map and carrier types of the flash self-write control block
`default_nettype none

package fswc_pkg;

   // ==========================================================================
   // clock and timing
   // ==========================================================================
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned PROG_CYCLES_DEF = 20000;

   // ==========================================================================
   // register byte offsets on the bus
   // ==========================================================================
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_UNLOCK = 8'h04;
   localparam logic [7:0] OFS_LATCH = 8'h08;
   localparam logic [7:0] OFS_PTR_LOW = 8'h0c;
   localparam logic [7:0] OFS_PTR_HIGH = 8'h10;
   localparam logic [7:0] OFS_PTR_UPPER = 8'h14;
   localparam logic [7:0] OFS_SPACE = 8'h18;
   localparam logic [7:0] OFS_TBL_CMD = 8'h1c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

   // ==========================================================================
   // flash_control field positions and reset values
   // ==========================================================================
   localparam int unsigned CTL_WORD = 5;
   localparam int unsigned CTL_ERASE = 4;
   localparam int unsigned CTL_ERR = 3;
   localparam int unsigned CTL_WRITE_ENABLE_GATE = 2;
   localparam int unsigned CTL_START = 1;
   localparam logic RST_WORD = 1'b0;
   localparam logic RST_ERASE = 1'b0;
   localparam logic RST_ERR = 1'b0;
   localparam logic RST_WRITE_ENABLE_GATE = 1'b0;
   localparam logic RST_START = 1'b0;

   // unlock keys
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

   // ==========================================================================
   // table command fields and pointer update modes
   // ==========================================================================
   localparam int unsigned CMD_WRITE = 0;
   localparam int unsigned CMD_MODE_LO = 1;
   localparam logic [1:0] PM_KEEP = 2'h0;
   localparam logic [1:0] PM_POST_INC = 2'h1;
   localparam logic [1:0] PM_POST_DEC = 2'h2;
   localparam logic [1:0] PM_PRE_INC = 2'h3;

   // pointer geometry
   localparam int unsigned PTR_W = 22;
   localparam int unsigned PTR_LOW_W = 21;
   localparam int unsigned HOLD_IDX_W = 7;
   localparam int unsigned BLK_LSB = 10;
   localparam int unsigned BLK_W = 12;
   localparam logic [21:0] RST_PTR = 22'h000000;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [1:0] RST_SPACE = 2'h0;

   // ==========================================================================
   // interrupt status bits
   // ==========================================================================
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_ERR = 1;
   localparam int unsigned IRQ_TBL = 2;
   localparam int unsigned IRQ_REFUSED = 3;
   localparam logic [3:0] RST_IRQ = 4'h0;

   // ==========================================================================
   // types
   // ==========================================================================
   typedef struct packed {
      logic word_sel;
      logic erase_sel;
      logic err;
      logic wr_en;
      logic start;
   } fswc_ctrl_t;

   typedef struct packed {
      logic erase;
      logic word;
      logic [11:0] block;
   } fswc_prog_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROG,
      ST_READ
   } fswc_state_t;

endpackage

`default_nettype wire

//--- fswc_top.sv
// flash self-write control: control register, unlock port, table latch and pointer, apb slave
//
// Functional notes
// - unlock port stores nothing and always reads as zero.
// - word select one programs two bytes, zero programs a 128-byte block.
// - erase select makes next start an erase; erase completion clears it.
// - write enable gates every program and erase cycle; zero after power-up.
// - error flag set when start is set, cleared on normal timer completion.
// - error flag left high means cycle cut by reset or improper attempt.
// - setting start launches selected cycle, timed by internal programming timer.
// - software can only set start; hardware clears it at cycle completion.
// - memory and config space selects are never cleared on write error.
// - table data latch is an 8-bit byte holder for table transfers.
// - pointer is upper, high and low bytes joined into 22 bits.
// - low 21 bits address program memory; top bit selects config space.
// - table instructions update pointer in one of four ways.
// - automatic pointer updates touch only the low 21 bits.
// - modes: keep, increment after, decrement after, increment before.
// - table write uses bits 6:0; program cycle uses bits 21:10.
// - instruction fetch stalls while a program or erase cycle runs.
`default_nettype none

module fswc_top
   import fswc_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = fswc_pkg::PROG_CYCLES_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic core_reset_req,
   output logic fetch_stall,
   output logic prog_start,
   output fswc_pkg::fswc_prog_req_t prog_req,
   output logic mem_rd_req,
   output logic [21:0] mem_addr,
   input wire logic mem_rd_valid,
   input wire logic [7:0] mem_rd_data,
   output logic hold_wr,
   output logic [6:0] hold_idx,
   output logic [7:0] hold_data
);

   import fswc_pkg::*;

   localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

   // ============
   // helpers
   // ============
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFS_CTRL) || (a == OFS_UNLOCK) || (a == OFS_LATCH) ||
                  (a == OFS_PTR_LOW) || (a == OFS_PTR_HIGH) || (a == OFS_PTR_UPPER) ||
                  (a == OFS_SPACE) || (a == OFS_TBL_CMD) || (a == OFS_IRQ_STAT) ||
                  (a == OFS_IRQ_MASK);
   endfunction

   // top bit is carried through untouched
   function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic dn);
      logic [20:0] low;
      low = dn ? (p[20:0] - 21'h000001) : (p[20:0] + 21'h000001);
      ptr_step = {p[21], low};
   endfunction

   // ============
   // state
   // ============
   fswc_state_t state_ff;
   fswc_ctrl_t ctrl_ff;
   logic [1:0] space_ff;
   logic [7:0] latch_ff;
   logic [21:0] ptr_ff;
   logic [31:0] cnt_ff;
   logic key1_seen_ff;
   logic armed_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;
   logic fetch_stall_ff;
   logic prog_start_ff;
   fswc_prog_req_t prog_req_ff;
   logic mem_rd_req_ff;
   logic [21:0] mem_addr_ff;
   logic hold_wr_ff;
   logic [6:0] hold_idx_ff;
   logic [7:0] hold_data_ff;

   // ============
   // bus decode
   // ============
   logic setup;
   logic acc;
   logic wr_acc;
   logic rd_acc;
   logic wr_ctrl;
   logic wr_unlock;
   logic wr_cmd;
   logic start_req;
   logic start_ok;
   logic prog_end;
   logic cmd_ok;
   logic [1:0] cmd_mode;
   logic [21:0] eff_ptr;
   logic [3:0] ev;

   assign setup = psel & ~penable;
   assign acc = psel & penable & pready_ff;
   assign wr_acc = acc & pwrite;
   assign rd_acc = acc & ~pwrite;
   assign wr_ctrl = wr_acc & (paddr == OFS_CTRL);
   assign wr_unlock = wr_acc & (paddr == OFS_UNLOCK);
   assign wr_cmd = wr_acc & (paddr == OFS_TBL_CMD);
   // a zero in the start bit is simply no request
   assign start_req = wr_ctrl & pwdata[CTL_START] & (state_ff == ST_IDLE);
   // gate needs both the enable and a fresh unlock
   assign start_ok = start_req & armed_ff & pwdata[CTL_WRITE_ENABLE_GATE];
   assign prog_end = (state_ff == ST_PROG) & (cnt_ff == PROG_LAST) & ~core_reset_req;
   assign cmd_ok = wr_cmd & (state_ff == ST_IDLE);
   assign cmd_mode = pwdata[CMD_MODE_LO +: 2];
   // pre-increment addresses the stepped pointer
   assign eff_ptr = (cmd_mode == PM_PRE_INC) ? ptr_step(ptr_ff, 1'b0) : ptr_ff;

   always_comb begin
      ev = 4'h0;
      ev[IRQ_DONE] = prog_end;
      ev[IRQ_ERR] = (start_req & ~start_ok) |
                    ((state_ff == ST_PROG) & core_reset_req);
      ev[IRQ_TBL] = (cmd_ok & pwdata[CMD_WRITE]) | ((state_ff == ST_READ) & mem_rd_valid);
      ev[IRQ_REFUSED] = wr_cmd & (state_ff != ST_IDLE);
   end

   // ============
   // apb response, zero wait states
   // ============
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            pslverr_ff <= ~is_mapped(paddr);
            prdata_ff <= 32'h00000000;
            if (!pwrite) begin
               case (paddr)
                  OFS_CTRL: prdata_ff <= {26'h0, ctrl_ff, 1'b0};
                  OFS_UNLOCK: prdata_ff <= 32'h00000000;
                  OFS_LATCH: prdata_ff <= {24'h0, latch_ff};
                  OFS_PTR_LOW: prdata_ff <= {24'h0, ptr_ff[7:0]};
                  OFS_PTR_HIGH: prdata_ff <= {24'h0, ptr_ff[15:8]};
                  OFS_PTR_UPPER: prdata_ff <= {26'h0, ptr_ff[21:16]};
                  OFS_SPACE: prdata_ff <= {30'h0, space_ff};
                  OFS_IRQ_STAT: prdata_ff <= {28'h0, irq_stat_ff};
                  OFS_IRQ_MASK: prdata_ff <= {28'h0, irq_mask_ff};
                  default: prdata_ff <= 32'h00000000;
               endcase
            end
         end
      end
   end

   // ============
   // unlock sequence tracker
   // ============
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key1_seen_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else if (core_reset_req || wr_ctrl) begin
         // any control write consumes the arming, used or not
         key1_seen_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else if (wr_unlock) begin
         key1_seen_ff <= (pwdata[7:0] == UNLOCK_KEY1);
         armed_ff <= key1_seen_ff & (pwdata[7:0] == UNLOCK_KEY2);
      end
   end

   // ============
   // control register and programming timer
   // ============
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= '{word_sel: RST_WORD, erase_sel: RST_ERASE, err: RST_ERR,
                      wr_en: RST_WRITE_ENABLE_GATE, start: RST_START};
         state_ff <= ST_IDLE;
         cnt_ff <= 32'h00000000;
         fetch_stall_ff <= 1'b0;
         prog_start_ff <= 1'b0;
         prog_req_ff <= '0;
         mem_rd_req_ff <= 1'b0;
         mem_addr_ff <= RST_PTR;
      end else begin
         prog_start_ff <= 1'b0;
         mem_rd_req_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (wr_ctrl) begin
                  ctrl_ff.word_sel <= pwdata[CTL_WORD];
                  ctrl_ff.erase_sel <= pwdata[CTL_ERASE];
                  ctrl_ff.wr_en <= pwdata[CTL_WRITE_ENABLE_GATE];
                  ctrl_ff.err <= pwdata[CTL_ERR];
               end
               if (start_ok) begin
                  ctrl_ff.start <= 1'b1;
                  ctrl_ff.err <= 1'b1;
                  state_ff <= ST_PROG;
                  cnt_ff <= 32'h00000000;
                  fetch_stall_ff <= 1'b1;
                  prog_start_ff <= 1'b1;
                  prog_req_ff.erase <= pwdata[CTL_ERASE];
                  prog_req_ff.word <= pwdata[CTL_WORD];
                  prog_req_ff.block <= ptr_ff[BLK_LSB +: BLK_W];
               end else if (start_req) begin
                  // improper attempt: flag stays up for software to see
                  ctrl_ff.err <= 1'b1;
               end else if (cmd_ok && !pwdata[CMD_WRITE]) begin
                  state_ff <= ST_READ;
                  mem_rd_req_ff <= 1'b1;
                  mem_addr_ff <= eff_ptr;
               end
            end
            ST_PROG: begin
               cnt_ff <= cnt_ff + 32'h00000001;
               if (core_reset_req) begin
                  // cut short: start drops, error is left set
                  ctrl_ff.start <= 1'b0;
                  ctrl_ff.wr_en <= 1'b0;
                  state_ff <= ST_IDLE;
                  fetch_stall_ff <= 1'b0;
               end else if (prog_end) begin
                  ctrl_ff.start <= 1'b0;
                  ctrl_ff.err <= 1'b0;
                  if (prog_req_ff.erase) begin
                     ctrl_ff.erase_sel <= 1'b0;
                  end
                  state_ff <= ST_IDLE;
                  fetch_stall_ff <= 1'b0;
               end
            end
            ST_READ: begin
               if (mem_rd_valid) begin
                  state_ff <= ST_IDLE;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ============
   // space selects, kept on error so the failing access can be traced
   // ============
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         space_ff <= RST_SPACE;
      end else if (wr_acc && (paddr == OFS_SPACE)) begin
         space_ff <= pwdata[1:0];
      end
   end

   // ============
   // table data latch and holding-register write
   // ============
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_ff <= RST_LATCH;
         hold_wr_ff <= 1'b0;
         hold_idx_ff <= 7'h00;
         hold_data_ff <= 8'h00;
      end else begin
         hold_wr_ff <= 1'b0;
         if ((state_ff == ST_READ) && mem_rd_valid) begin
            latch_ff <= mem_rd_data;
         end else if (wr_acc && (paddr == OFS_LATCH)) begin
            latch_ff <= pwdata[7:0];
         end
         if (cmd_ok && pwdata[CMD_WRITE]) begin
            hold_wr_ff <= 1'b1;
            hold_idx_ff <= eff_ptr[HOLD_IDX_W-1:0];
            hold_data_ff <= latch_ff;
         end
      end
   end

   // ============
   // table byte pointer
   // ============
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_ff <= RST_PTR;
      end else if (cmd_ok) begin
         case (cmd_mode)
            PM_KEEP: ptr_ff <= ptr_ff;
            PM_POST_INC: ptr_ff <= ptr_step(ptr_ff, 1'b0);
            PM_POST_DEC: ptr_ff <= ptr_step(ptr_ff, 1'b1);
            PM_PRE_INC: ptr_ff <= eff_ptr;
            default: ptr_ff <= ptr_ff;
         endcase
      end else if (wr_acc && (paddr == OFS_PTR_LOW)) begin
         ptr_ff[7:0] <= pwdata[7:0];
      end else if (wr_acc && (paddr == OFS_PTR_HIGH)) begin
         ptr_ff[15:8] <= pwdata[7:0];
      end else if (wr_acc && (paddr == OFS_PTR_UPPER)) begin
         ptr_ff[21:16] <= pwdata[5:0];
      end
   end

   // ============
   // interrupts: sticky status, read-to-clear, masked level output
   // ============
   logic [3:0] nxt_irq_stat;
   logic [3:0] clr_bits;

   always_comb begin
      clr_bits = 4'h0;
      // only bits the reader actually saw are cleared; a new event still wins
      if (rd_acc && (paddr == OFS_IRQ_STAT)) begin
         clr_bits = prdata_ff[3:0];
      end
      nxt_irq_stat = (irq_stat_ff & ~clr_bits) | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= RST_IRQ;
         irq_mask_ff <= RST_IRQ;
         irq_ff <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         if (wr_acc && (paddr == OFS_IRQ_MASK)) begin
            irq_mask_ff <= pwdata[3:0];
         end
         irq_ff <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   // ============
   // outputs
   // ============
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign fetch_stall = fetch_stall_ff;
   assign prog_start = prog_start_ff;
   assign prog_req = prog_req_ff;
   assign mem_rd_req = mem_rd_req_ff;
   assign mem_addr = mem_addr_ff;
   assign hold_wr = hold_wr_ff;
   assign hold_idx = hold_idx_ff;
   assign hold_data = hold_data_ff;

endmodule

`default_nettype wire

//--- fswc_top_assertions.sv
// concurrent checks on the ports of the flash self-write control block
`default_nettype none
module fswc_top_assertions
   import fswc_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic core_reset_req,
   input wire logic fetch_stall,
   input wire logic prog_start,
   input wire logic mem_rd_req,
   input wire logic hold_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] run_ff;
   // ============
   // stall length so far
   // ============
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= 32'h0;
      end else begin
         run_ff <= fetch_stall ? run_ff + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd(logic [7:0] a);
      psel && penable && pready && !pwrite && paddr == a;
   endsequence
   // ============
   // properties
   // ============
   property p_stall_len;
      $fell(fetch_stall) && !$past(core_reset_req) && !$past(core_reset_req, 2)
         |-> $past(run_ff) == PROG_CYCLES - 1;
   endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
   property p_stall_cap;
      fetch_stall |-> run_ff < PROG_CYCLES;
   endproperty
   a_stall_cap: assert property (p_stall_cap) else $error("stall too long");
   property p_launch;
      prog_start |-> fetch_stall && $past(psel && penable && pwrite && paddr == OFS_CTRL
         && pwdata[CTL_START] && pwdata[CTL_WRITE_ENABLE_GATE]);
   endproperty
   a_launch: assert property (p_launch) else $error("launch without start");
   property p_stall_rise;
      $rose(fetch_stall) |-> prog_start;
   endproperty
   a_stall_rise: assert property (p_stall_rise) else $error("stall without launch");
   property p_core_abort;
      fetch_stall && core_reset_req |-> ##[1:2] !fetch_stall;
   endproperty
   a_core_abort: assert property (p_core_abort) else $error("abort ignored");
   property p_hold;
      hold_wr |-> $past(psel && penable && pwrite && paddr == OFS_TBL_CMD && pwdata[CMD_WRITE]);
   endproperty
   a_hold: assert property (p_hold) else $error("stray holding write");
   property p_read;
      mem_rd_req |-> $past(psel && penable && pwrite && paddr == OFS_TBL_CMD
         && !pwdata[CMD_WRITE]);
   endproperty
   a_read: assert property (p_read) else $error("stray table read");
   property p_unlock;
      s_setup ##1 s_rd(OFS_UNLOCK) |-> prdata == 32'h0;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock port not zero");
   property p_busy;
      (s_setup and (fetch_stall && !core_reset_req && !$past(core_reset_req)))
         ##1 s_rd(OFS_CTRL) |-> prdata[CTL_START] && prdata[CTL_ERR];
   endproperty
   a_busy: assert property (p_busy) else $error("start or error low in cycle");
endmodule

bind fswc_top fswc_top_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .core_reset_req(core_reset_req),
   .fetch_stall(fetch_stall), .prog_start(prog_start), .mem_rd_req(mem_rd_req),
   .hold_wr(hold_wr));
`default_nettype wire

//--- fswc_flash_model.sv
// flash array stand-in answering table reads after a varying delay
`default_nettype none
module fswc_flash_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_rd_req,
   input wire logic [21:0] mem_addr,
   output logic mem_rd_valid,
   output logic [7:0] mem_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_ff;
   logic slow_ff;
   logic [7:0] byte_ff;
   // prompt and slow answers alternate; idle data keeps toggling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_ff <= 3'h0;
         slow_ff <= 1'b0;
         byte_ff <= 8'h00;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 8'h00;
      end else begin
         mem_rd_valid <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
         if (mem_rd_req) begin
            wait_ff <= slow_ff ? 3'h4 : 3'h1;
            slow_ff <= ~slow_ff;
            byte_ff <= mem_addr[7:0] ^ 8'h3c;
         end else if (wait_ff == 3'h1) begin
            wait_ff <= 3'h0;
            mem_rd_valid <= 1'b1;
            mem_rd_data <= byte_ff;
         end else if (wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- fswc_top_test.sv
// self-checking bench of the flash self-write control block
`default_nettype none
module fswc_top_test import fswc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned PC = 16;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic core_reset_req = 1'b0, serr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, fetch_stall, prog_start, mem_rd_req, mem_rd_valid, hold_wr;
   fswc_prog_req_t prog_req;
   logic [21:0] mem_addr;
   logic [7:0] mem_rd_data, hold_data;
   logic [6:0] hold_idx;
   int bad_count = 0, compares = 0, starts = 0, holds = 0, reads = 0;
   always #5 pclk = ~pclk;
   fswc_top #(.PROG_CYCLES(PC)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .core_reset_req(core_reset_req),
      .fetch_stall(fetch_stall), .prog_start(prog_start), .prog_req(prog_req),
      .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data), .hold_wr(hold_wr), .hold_idx(hold_idx),
      .hold_data(hold_data));
   fswc_flash_model u_flash (.pclk(pclk), .presetn(presetn), .mem_rd_req(mem_rd_req),
      .mem_addr(mem_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));
   // pulses last one cycle
   always @(posedge pclk) begin
      if (presetn) begin
         starts <= starts + int'(prog_start);
         holds <= holds + int'(hold_wr);
         reads <= reads + int'(mem_rd_req);
      end
   end
   // ============
   // report and bus tasks
   // ============
   task automatic summarize;
      $display("bad_count %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // idle cycle between transfers: one assignment per edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      int n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         summarize();
      end
      q = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      apb(a, 1'b0, 32'h0, q);
   endtask
   task automatic set_ptr(input logic [21:0] p);
      wr(OFS_PTR_LOW, {24'h0, p[7:0]});
      wr(OFS_PTR_HIGH, {24'h0, p[15:8]});
      wr(OFS_PTR_UPPER, {26'h0, p[21:16]});
   endtask
   task automatic get_ptr(output logic [21:0] p);
      logic [31:0] q;
      rd(OFS_PTR_LOW, q);
      p[7:0] = q[7:0];
      rd(OFS_PTR_HIGH, q);
      p[15:8] = q[7:0];
      rd(OFS_PTR_UPPER, q);
      p[21:16] = q[5:0];
   endtask
   task automatic wait_tbl;
      logic [31:0] q = 32'h0;
      int n = 0;
      while (q[IRQ_TBL] !== 1'b1) begin
         if (n == 20) begin
            bad_count++;
            summarize();
         end
         n++;
         rd(OFS_IRQ_STAT, q);
      end
   endtask
   task automatic unlock;
      wr(OFS_UNLOCK, 32'h55);
      wr(OFS_UNLOCK, 32'haa);
   endtask
   // ============
   // scenarios
   // ============
   task automatic t_reset;
      logic [31:0] q;
      rd(OFS_CTRL, q);
      chk(q, 32'h0);
      wr(OFS_UNLOCK, 32'h55);
      rd(OFS_UNLOCK, q);
      chk(q, 32'h0);
      rd(OFS_LATCH, q);
      chk(q, 32'h0);
      rd(8'h40, q);
      chk({q[30:0], serr}, 32'h1);
      wr(OFS_IRQ_MASK, 32'h1);
   endtask
   task automatic t_refused(input logic arm);
      logic [31:0] q;
      if (arm) begin
         unlock();
      end
      wr(OFS_CTRL, arm ? 32'h02 : 32'h06);
      #1;
      chk({30'h0, starts != 0, fetch_stall}, 32'h0);
      @(posedge pclk);
      rd(OFS_CTRL, q);
      chk(q, arm ? 32'h8 : 32'hc);
      rd(OFS_IRQ_STAT, q);
      chk({q[30:0], irq}, 32'h4);
   endtask
   task automatic t_prog(input logic wd, input logic er, input logic [21:0] p);
      logic [31:0] q, c;
      int n;
      c = {26'h0, wd, er, 4'h4};
      set_ptr(p);
      wr(OFS_CTRL, c);
      unlock();
      n = starts + 1;
      wr(OFS_CTRL, c | 32'h2);
      #1;
      chk({17'h0, starts == n, prog_req}, {17'h0, 1'b1, er, wd, p[21:10]});
      n = 1; // launch edge already passed
      while (fetch_stall === 1'b1 && n < 100) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk(n, PC);
      @(posedge pclk);
      rd(OFS_CTRL, q);
      chk({q[30:0], irq}, {25'h0, wd, 6'h9});
      rd(OFS_IRQ_STAT, q);
      #1;
      chk({q[30:0], irq}, 32'h2);
      @(posedge pclk);
   endtask
   task automatic t_core;
      logic [31:0] q;
      wr(OFS_SPACE, 32'h3);
      wr(OFS_CTRL, 32'h4);
      unlock();
      wr(OFS_CTRL, 32'h6);
      wr(OFS_CTRL, 32'h0);
      rd(OFS_CTRL, q);
      chk(q, 32'he);
      core_reset_req <= 1'b1;
      @(posedge pclk);
      core_reset_req <= 1'b0;
      @(posedge pclk);
      #1;
      chk({31'h0, fetch_stall}, 32'h0);
      @(posedge pclk);
      rd(OFS_CTRL, q);
      chk(q, 32'h8);
      rd(OFS_SPACE, q);
      chk(q, 32'h3);
      rd(OFS_IRQ_STAT, q);
      chk(q, 32'h2);
   endtask
   task automatic t_table;
      logic [31:0] q;
      logic [21:0] p, a, e;
      for (int m = 0; m < 4; m++) begin
         set_ptr(22'h3fffff);
         wr(OFS_TBL_CMD, {29'h0, m[1:0], 1'b0});
         #1;
         a = (m == 3) ? 22'h200000 : 22'h3fffff;
         e = (m[0] == 1'b1) ? 22'h200000 : (m == 2 ? 22'h3ffffe : 22'h3fffff);
         chk({9'h0, reads == m + 1, mem_addr}, {9'h0, 1'b1, a});
         @(posedge pclk);
         // second read answers slowly: this command lands while it is pending
         if (m == 1) begin
            wr(OFS_TBL_CMD, 32'h3);
            rd(OFS_IRQ_STAT, q);
            chk({31'h0, q[IRQ_REFUSED]}, 32'h1);
         end
         wait_tbl();
         rd(OFS_LATCH, q);
         chk(q, {24'h0, a[7:0] ^ 8'h3c});
         get_ptr(p);
         chk({10'h0, p}, {10'h0, e});
      end
      set_ptr(22'h200000);
      wr(OFS_LATCH, 32'ha5);
      wr(OFS_TBL_CMD, 32'h5);
      #1;
      chk({16'h0, holds == 1, hold_idx, hold_data}, {16'h0, 1'b1, 7'h00, 8'ha5});
      @(posedge pclk);
      wait_tbl();
      get_ptr(p);
      chk({10'h0, p}, {10'h0, 22'h3fffff});
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_refused(1'b0);
      t_refused(1'b1);
      t_prog(1'b1, 1'b0, 22'h0a5400);
      t_prog(1'b0, 1'b0, 22'h1ffc00);
      t_prog(1'b0, 1'b1, 22'h000fff);
      t_core();
      t_table();
      summarize();
   end
endmodule
`default_nettype wire
